// ===== pkg/dmdc_consts.svh
// constants of the mode and DLL control block: offsets, field positions, timings
// assumes the controller clock runs at 40 MHz and divides it for the link clock
`ifndef DMDC_CONSTS_SVH
`define DMDC_CONSTS_SVH

// ****************
// clocking
// ****************
`define DMDC_SYS_MHZ 40
`define DMDC_FAST_HALF 3'h1
`define DMDC_SLOW_HALF 3'h4
`define DMDC_TCK_NS (2 * 1000 / `DMDC_SYS_MHZ)

// ****************
// timings, printed unit first, then link clock periods (rounded up)
// ****************
`define DMDC_TRP_NS 15
`define DMDC_TXS_NS 170
`define DMDC_TCKSRE_NS 10
`define DMDC_TCKSRX_NS 10
`define DMDC_TRP_CK ((`DMDC_TRP_NS + `DMDC_TCK_NS - 1) / `DMDC_TCK_NS)
`define DMDC_TXS_CK ((`DMDC_TXS_NS + `DMDC_TCK_NS - 1) / `DMDC_TCK_NS)
`define DMDC_TCKSRE_CK ((`DMDC_TCKSRE_NS + `DMDC_TCK_NS - 1) / `DMDC_TCK_NS)
`define DMDC_TCKSRX_CK ((`DMDC_TCKSRX_NS + `DMDC_TCK_NS - 1) / `DMDC_TCK_NS)
`define DMDC_TMOD_CK 12
`define DMDC_TMRD_CK 4
`define DMDC_TDLLK_CK 512

// ****************
// commands as {ras_n, cas_n, we_n} and bank codes
// ****************
`define DMDC_CMD_MRS 3'h0
`define DMDC_CMD_REF 3'h1
`define DMDC_CMD_PRE 3'h2
`define DMDC_CMD_WR 3'h4
`define DMDC_CMD_RD 3'h5
`define DMDC_CMD_NOP 3'h7
`define DMDC_BA_MR0 3'h0
`define DMDC_BA_MR1 3'h1
`define DMDC_BA_MR2 3'h2
`define DMDC_BA_MR3 3'h3

// ****************
// mode register fields and values
// ****************
`define DMDC_MR1_DLL_BIT 0
`define DMDC_MR1_LVL_BIT 7
`define DMDC_MR3_CAL_BIT 2
`define DMDC_MR0_CL6 13'h0020
`define DMDC_MR0_DLL_RST 13'h0100
`define DMDC_MR1_DLL_OFF 13'h0001
`define DMDC_MR2_CWL6 13'h0008
`define DMDC_MR3_CAL 13'h0004
`define DMDC_MR3_KEEP 13'h0007
`define DMDC_ADDR_ZERO 13'h0000
`define DMDC_PRE_ALL 13'h0400
`define DMDC_CAL_PATTERN 8'h55
`define DMDC_CL_BASE 5'h04

`endif

// ===== pkg/dmdc_pkg.sv
// types shared by both ends of the mode and DLL control block
// assumes dmdc_consts.svh is on the include path
package dmdc_pkg;
    typedef enum logic [2:0] {
        OP_RAW, OP_DLL_OFF, OP_DLL_ON, OP_CAL_ON, OP_CAL_OFF
    } dmdc_op_t;

    typedef enum logic [4:0] {
        SQ_INIT, SQ_IDLE, SQ_WAIT,
        SQ_OFF_MR2, SQ_OFF_MR1, SQ_OFF_SRE, SQ_OFF_FREQ, SQ_OFF_SRX, SQ_OFF_MR0, SQ_OFF_CWL,
        SQ_ON_SRE, SQ_ON_FREQ, SQ_ON_SRX, SQ_ON_MR1, SQ_ON_RST, SQ_ON_LAT,
        SQ_CAL_PRE, SQ_CAL_MRS, SQ_CAL_OFF
    } dmdc_seq_t;

    typedef struct packed {
        dmdc_seq_t st;
        dmdc_seq_t ret;
        logic [9:0] cnt;
        logic [2:0] div;
        logic ck;
        logic slow;
        logic cke;
        logic cs_n;
        logic [2:0] cmd;
        logic [2:0] ba;
        logic [12:0] addr;
        logic odt;
        logic rst_n;
        logic dll_off;
        logic cal;
        logic dqs_q;
        logic rd_vld;
        logic [7:0] rd_data;
    } dmdc_ctl_st_t;

    typedef struct packed {
        logic [12:0] mr0;
        logic [12:0] mr1;
        logic [12:0] mr2;
        logic [12:0] mr3;
        logic dll_off;
        logic cal;
        logic sr;
        logic [31:0] pipe;
        logic dqs;
        logic [7:0] dq;
        logic arr_rd;
        logic [12:0] col;
        logic [1:0] rtt_wr;
        logic [2:0] rtt_nom;
        logic wr_apply;
    } dmdc_dev_st_t;
endpackage

// ===== pkg/dmdc_if.sv
// link between memory controller and memory device: clock, command, read data
// assumes the controller end drives ck; read data is one-way toward it
`timescale 1ns/1ps
`default_nettype none
interface dmdc_if;
    logic ck;
    logic reset_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [12:0] addr;
    logic odt;
    logic [7:0] dq;
    logic dqs;

    modport ctrl (
        output ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
        input dq, dqs
    );
    modport dev (
        input ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
        output dq, dqs
    );
endinterface
`default_nettype wire

// ===== rtl/dmdc_sync.sv
// three-stage synchroniser; an output bit follows once stages two and three agree
// assumes i_d comes from another clock domain, bits independent of each other
`timescale 1ns/1ps
`default_nettype none
module dmdc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } dmdc_sync_st_t;

    dmdc_sync_st_t r_ff;
    dmdc_sync_st_t nxt_r;
    logic [W-1:0] agree;

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            assign agree[gi] = (r_ff.s2[gi] == r_ff.s3[gi]) ? r_ff.s2[gi] : r_ff.q[gi];
        end
    endgenerate

    always_comb begin
        nxt_r = r_ff;
        nxt_r.s1 = i_d;
        nxt_r.s2 = r_ff.s1;
        nxt_r.s3 = r_ff.s2;
        nxt_r.q = agree;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign o_q = r_ff.q;
endmodule
`default_nettype wire

// ===== rtl/dmdc_dev.sv
// memory device end: command decode, mode registers, read latency and termination
// assumes the link clock and reset come from the controller over dmdc_if
`timescale 1ns/1ps
`default_nettype none
`include "dmdc_consts.svh"
module dmdc_dev (
    // link
    dmdc_if.dev link,
    // status domain
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // array side, link clock domain
    input wire logic [7:0] i_array_data,
    output logic o_array_rd,
    output logic [12:0] o_array_col,
    // termination, link clock domain
    output logic [2:0] o_rtt_nom,
    output logic [1:0] o_rtt_wr,
    output logic o_rtt_wr_apply,
    // status, system clock domain
    output logic o_dll_off,
    output logic o_cal_on
);
    dmdc_pkg::dmdc_dev_st_t r_ff;
    dmdc_pkg::dmdc_dev_st_t nxt_r;
    logic [2:0] cmd;
    logic [4:0] cl;
    logic [4:0] al;
    logic [4:0] lat;
    logic rd;
    logic [7:0] cal_data;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.arr_rd = 1'b0;
        nxt_r.wr_apply = 1'b0;
        cmd = {link.ras_n, link.cas_n, link.we_n};
        rd = 1'b0;
        // deselect and no-operation fall through with no effect
        if (!link.cs_n && link.cke) begin
            case (cmd)
                `DMDC_CMD_MRS: begin
                    case (link.ba)
                        `DMDC_BA_MR0: nxt_r.mr0 = link.addr;
                        `DMDC_BA_MR1: begin
                            nxt_r.mr1 = link.addr;
                            nxt_r.dll_off = link.addr[`DMDC_MR1_DLL_BIT];
                        end
                        `DMDC_BA_MR2: nxt_r.mr2 = link.addr;
                        `DMDC_BA_MR3: begin
                            nxt_r.mr3 = link.addr;
                            nxt_r.cal = link.addr[`DMDC_MR3_CAL_BIT];
                        end
                        default: nxt_r.mr0 = r_ff.mr0;
                    endcase
                end
                `DMDC_CMD_RD: begin
                    rd = 1'b1;
                    // in pattern mode the array is left alone
                    nxt_r.arr_rd = !r_ff.cal;
                    nxt_r.col = link.addr;
                end
                `DMDC_CMD_WR: nxt_r.wr_apply = link.odt && (r_ff.rtt_wr != 2'h0);
                default: nxt_r.sr = r_ff.sr;
            endcase
        end
        if (!link.cs_n && !link.cke && (cmd == `DMDC_CMD_REF)) begin
            nxt_r.sr = 1'b1;
        end else if (link.cke) begin
            nxt_r.sr = 1'b0;
        end
        // leveling keeps the nominal value only
        nxt_r.rtt_wr = r_ff.mr1[`DMDC_MR1_LVL_BIT] ? 2'h0 : r_ff.mr2[10:9];
        nxt_r.rtt_nom = {r_ff.mr1[9], r_ff.mr1[6], r_ff.mr1[2]};
        cl = {2'h0, r_ff.mr0[6:4]} + `DMDC_CL_BASE;
        case (r_ff.mr1[4:3])
            2'h1: al = cl - 5'h01;
            2'h2: al = cl - 5'h02;
            default: al = 5'h00;
        endcase
        // strobe one period earlier with the DLL off
        lat = al + cl - {4'h0, r_ff.dll_off};
        // pattern select counts only while pattern mode is on
        cal_data = (r_ff.mr3[2] && (r_ff.mr3[1:0] == 2'h0)) ? `DMDC_CAL_PATTERN : 8'h00;
        nxt_r.pipe = {r_ff.pipe[30:0], rd};
        nxt_r.dqs = r_ff.pipe[lat - 5'h01];
        if (r_ff.pipe[lat - 5'h01]) begin
            nxt_r.dq = r_ff.cal ? cal_data : i_array_data;
        end
    end

    // reset pin works in every mode, pattern readout included
    always_ff @(posedge link.ck) begin
        if (!link.reset_n) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    dmdc_sync #(
        .W(2)
    ) u_status_sync (
        .i_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_d({r_ff.dll_off, r_ff.cal}),
        .o_q({o_dll_off, o_cal_on})
    );

    assign link.dq = r_ff.dq;
    assign link.dqs = r_ff.dqs;
    assign o_array_rd = r_ff.arr_rd;
    assign o_array_col = r_ff.col;
    assign o_rtt_nom = r_ff.rtt_nom;
    assign o_rtt_wr = r_ff.rtt_wr;
    assign o_rtt_wr_apply = r_ff.wr_apply;
endmodule
`default_nettype wire

// ===== rtl/dmdc_ctl.sv
// memory controller end: link clock divider, command issue, DLL and pattern sequences
// assumes a 40 MHz system clock; the device end samples commands on ck rising
//
// What this block and the device end do
// - dynamic write termination from register two bits
// - zero dynamic termination before DLL off
// - write leveling uses nominal termination only
// - register three written by its bank code
// - reserved register three bits sent as zero
// - pattern select ignored while pattern mode off
// - register three bit two enters pattern mode
// - precharge all and wait before pattern mode
// - reads answered from pattern register in mode
// - only reads or pattern exit during mode
// - reset works during pattern mode
// - no-operation registers no new command
// - deselect executes no new command
// - register one bit zero turns DLL off
// - DLL off uses latency six both ways
// - DLL off strobe one cycle earlier
// - DLL off allows a slow link clock
// - DLL off: set bit, self refresh, reclock
// - hold clock enable high, termination low
// - after exit wait, reprogram latencies, wait
// - DLL on keeps enable high until lock
// - wait DLL lock time after DLL reset
`timescale 1ns/1ps
`default_nettype none
`include "dmdc_consts.svh"
module dmdc_ctl (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // request
    input wire logic i_req_valid,
    input var dmdc_pkg::dmdc_op_t i_req_op,
    input wire logic [2:0] i_req_cmd,
    input wire logic [2:0] i_req_ba,
    input wire logic [12:0] i_req_addr,
    input wire logic i_req_odt,
    output logic o_req_ready,
    // status
    output logic o_busy,
    output logic o_dll_off,
    output logic o_cal_on,
    // read data
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    // link
    dmdc_if.ctrl link
);
    dmdc_pkg::dmdc_ctl_st_t r_ff;
    dmdc_pkg::dmdc_ctl_st_t nxt_r;
    logic [2:0] half;
    logic fall;
    logic allow;
    logic [8:0] lnk_q;

    // ****************
    // read return path
    // ****************
    // ck is ours but the strobe comes back through the device, so treat it as a pin
    dmdc_sync #(
        .W(9)
    ) u_rd_sync (
        .i_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_d({link.dqs, link.dq}),
        .o_q(lnk_q)
    );

    // ****************
    // sequencer
    // ****************
    function automatic dmdc_pkg::dmdc_ctl_st_t issue(
        input dmdc_pkg::dmdc_ctl_st_t s,
        input logic [2:0] c,
        input logic [2:0] b,
        input logic [12:0] a,
        input logic [9:0] w,
        input dmdc_pkg::dmdc_seq_t nx
    );
        dmdc_pkg::dmdc_ctl_st_t t;
        t = s;
        t.cs_n = 1'b0;
        t.cmd = c;
        t.ba = b;
        t.addr = a;
        t.odt = 1'b0;
        t.cnt = w;
        t.ret = nx;
        t.st = dmdc_pkg::SQ_WAIT;
        return t;
    endfunction

    always_comb begin
        nxt_r = r_ff;
        nxt_r.rd_vld = 1'b0;
        nxt_r.rst_n = (r_ff.st != dmdc_pkg::SQ_INIT);
        nxt_r.dqs_q = lnk_q[8];
        // a slow half period lets the DLL-off clock run far below the normal rate
        half = r_ff.slow ? `DMDC_SLOW_HALF : `DMDC_FAST_HALF;
        fall = r_ff.ck && (r_ff.div >= half - 3'h1);
        // in pattern mode only reads and the exit pass
        allow = !r_ff.cal || (i_req_op == dmdc_pkg::OP_CAL_OFF) ||
            ((i_req_op == dmdc_pkg::OP_RAW) && (i_req_cmd == `DMDC_CMD_RD));
        if (r_ff.div >= half - 3'h1) begin
            nxt_r.div = 3'h0;
            nxt_r.ck = !r_ff.ck;
        end else begin
            nxt_r.div = r_ff.div + 3'h1;
        end
        // commands change on the falling edge so they are settled at the rising edge
        if (fall) begin
            nxt_r.cs_n = 1'b1;
            nxt_r.cmd = `DMDC_CMD_NOP;
            case (r_ff.st)
                dmdc_pkg::SQ_INIT: begin
                    nxt_r.cke = 1'b1;
                    nxt_r.st = dmdc_pkg::SQ_IDLE;
                end
                dmdc_pkg::SQ_IDLE: begin
                    nxt_r.odt = 1'b0;
                    if (i_req_valid && allow) begin
                        case (i_req_op)
                            dmdc_pkg::OP_RAW: begin
                                nxt_r.cs_n = 1'b0;
                                nxt_r.cmd = i_req_cmd;
                                nxt_r.ba = i_req_ba;
                                nxt_r.addr = i_req_addr;
                                nxt_r.odt = i_req_odt;
                                if ((i_req_cmd == `DMDC_CMD_MRS) && (i_req_ba[1:0] == 2'h3)) begin
                                    nxt_r.ba = `DMDC_BA_MR3;
                                    nxt_r.addr = i_req_addr & `DMDC_MR3_KEEP;
                                    nxt_r.cal = i_req_addr[`DMDC_MR3_CAL_BIT];
                                end
                                if ((i_req_cmd == `DMDC_CMD_MRS) && (i_req_ba == `DMDC_BA_MR1)) begin
                                    nxt_r.dll_off = i_req_addr[`DMDC_MR1_DLL_BIT];
                                end
                            end
                            dmdc_pkg::OP_DLL_OFF: nxt_r.st = dmdc_pkg::SQ_OFF_MR2;
                            dmdc_pkg::OP_DLL_ON: nxt_r.st = dmdc_pkg::SQ_ON_SRE;
                            dmdc_pkg::OP_CAL_ON: nxt_r.st = dmdc_pkg::SQ_CAL_PRE;
                            dmdc_pkg::OP_CAL_OFF: nxt_r.st = dmdc_pkg::SQ_CAL_OFF;
                            default: nxt_r.st = dmdc_pkg::SQ_IDLE;
                        endcase
                    end
                end
                dmdc_pkg::SQ_WAIT: begin
                    if (r_ff.cnt <= 10'h001) begin
                        nxt_r.st = r_ff.ret;
                    end else begin
                        nxt_r.cnt = r_ff.cnt - 10'h001;
                    end
                end
                // ---- DLL on to off ----
                dmdc_pkg::SQ_OFF_MR2: begin
                    nxt_r = issue(nxt_r, `DMDC_CMD_MRS, `DMDC_BA_MR2, `DMDC_ADDR_ZERO,
                        10'(`DMDC_TMRD_CK), dmdc_pkg::SQ_OFF_MR1);
                end
                dmdc_pkg::SQ_OFF_MR1: begin
                    nxt_r = issue(nxt_r, `DMDC_CMD_MRS, `DMDC_BA_MR1, `DMDC_MR1_DLL_OFF,
                        10'(`DMDC_TMOD_CK), dmdc_pkg::SQ_OFF_SRE);
                    nxt_r.dll_off = 1'b1;
                end
                dmdc_pkg::SQ_OFF_SRE: begin
                    nxt_r = issue(nxt_r, `DMDC_CMD_REF, `DMDC_BA_MR0, `DMDC_ADDR_ZERO,
                        10'(`DMDC_TCKSRE_CK), dmdc_pkg::SQ_OFF_FREQ);
                    nxt_r.cke = 1'b0;
                end
                dmdc_pkg::SQ_OFF_FREQ: begin
                    nxt_r.slow = 1'b1;
                    nxt_r.cnt = 10'(`DMDC_TCKSRX_CK);
                    nxt_r.ret = dmdc_pkg::SQ_OFF_SRX;
                    nxt_r.st = dmdc_pkg::SQ_WAIT;
                end
                dmdc_pkg::SQ_OFF_SRX: begin
                    // enable stays high and termination low from here to the end
                    nxt_r = issue(nxt_r, `DMDC_CMD_NOP, `DMDC_BA_MR0, `DMDC_ADDR_ZERO,
                        10'(`DMDC_TXS_CK), dmdc_pkg::SQ_OFF_MR0);
                    nxt_r.cke = 1'b1;
                end
                dmdc_pkg::SQ_OFF_MR0: begin
                    nxt_r = issue(nxt_r, `DMDC_CMD_MRS, `DMDC_BA_MR0, `DMDC_MR0_CL6,
                        10'(`DMDC_TMRD_CK), dmdc_pkg::SQ_OFF_CWL);
                end
                dmdc_pkg::SQ_OFF_CWL: begin
                    nxt_r = issue(nxt_r, `DMDC_CMD_MRS, `DMDC_BA_MR2, `DMDC_MR2_CWL6,
                        10'(`DMDC_TMOD_CK), dmdc_pkg::SQ_IDLE);
                end
                // ---- DLL off to on ----
                dmdc_pkg::SQ_ON_SRE: begin
                    nxt_r = issue(nxt_r, `DMDC_CMD_REF, `DMDC_BA_MR0, `DMDC_ADDR_ZERO,
                        10'(`DMDC_TCKSRE_CK), dmdc_pkg::SQ_ON_FREQ);
                    nxt_r.cke = 1'b0;
                end
                dmdc_pkg::SQ_ON_FREQ: begin
                    nxt_r.slow = 1'b0;
                    nxt_r.cnt = 10'(`DMDC_TCKSRX_CK);
                    nxt_r.ret = dmdc_pkg::SQ_ON_SRX;
                    nxt_r.st = dmdc_pkg::SQ_WAIT;
                end
                dmdc_pkg::SQ_ON_SRX: begin
                    nxt_r = issue(nxt_r, `DMDC_CMD_NOP, `DMDC_BA_MR0, `DMDC_ADDR_ZERO,
                        10'(`DMDC_TXS_CK), dmdc_pkg::SQ_ON_MR1);
                    nxt_r.cke = 1'b1;
                end
                dmdc_pkg::SQ_ON_MR1: begin
                    nxt_r = issue(nxt_r, `DMDC_CMD_MRS, `DMDC_BA_MR1, `DMDC_ADDR_ZERO,
                        10'(`DMDC_TMRD_CK), dmdc_pkg::SQ_ON_RST);
                    nxt_r.dll_off = 1'b0;
                end
                dmdc_pkg::SQ_ON_RST: begin
                    nxt_r = issue(nxt_r, `DMDC_CMD_MRS, `DMDC_BA_MR0,
                        `DMDC_MR0_CL6 | `DMDC_MR0_DLL_RST,
                        10'(`DMDC_TMRD_CK), dmdc_pkg::SQ_ON_LAT);
                end
                dmdc_pkg::SQ_ON_LAT: begin
                    // lock wait also covers the mode register delay; no lock-needing work before
                    nxt_r = issue(nxt_r, `DMDC_CMD_MRS, `DMDC_BA_MR2, `DMDC_MR2_CWL6,
                        10'(`DMDC_TDLLK_CK), dmdc_pkg::SQ_IDLE);
                end
                // ---- pattern readout ----
                dmdc_pkg::SQ_CAL_PRE: begin
                    nxt_r = issue(nxt_r, `DMDC_CMD_PRE, `DMDC_BA_MR0, `DMDC_PRE_ALL,
                        10'(`DMDC_TRP_CK), dmdc_pkg::SQ_CAL_MRS);
                end
                dmdc_pkg::SQ_CAL_MRS: begin
                    nxt_r = issue(nxt_r, `DMDC_CMD_MRS, `DMDC_BA_MR3, `DMDC_MR3_CAL,
                        10'(`DMDC_TMOD_CK), dmdc_pkg::SQ_IDLE);
                    nxt_r.cal = 1'b1;
                end
                dmdc_pkg::SQ_CAL_OFF: begin
                    nxt_r = issue(nxt_r, `DMDC_CMD_MRS, `DMDC_BA_MR3, `DMDC_ADDR_ZERO,
                        10'(`DMDC_TMOD_CK), dmdc_pkg::SQ_IDLE);
                    nxt_r.cal = 1'b0;
                end
                default: nxt_r.st = dmdc_pkg::SQ_IDLE;
            endcase
        end
        // the device holds dq after a strobe, so it is settled once the strobe is
        if (lnk_q[8] && !r_ff.dqs_q) begin
            nxt_r.rd_vld = 1'b1;
            nxt_r.rd_data = lnk_q[7:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            r_ff <= '{st: dmdc_pkg::SQ_INIT, ret: dmdc_pkg::SQ_IDLE, cs_n: 1'b1,
                cmd: `DMDC_CMD_NOP, default: '0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ****************
    // outputs
    // ****************
    assign o_req_ready = (r_ff.st == dmdc_pkg::SQ_IDLE) && fall && allow;
    assign o_busy = (r_ff.st != dmdc_pkg::SQ_IDLE);
    assign o_dll_off = r_ff.dll_off;
    assign o_cal_on = r_ff.cal;
    assign o_rd_valid = r_ff.rd_vld;
    assign o_rd_data = r_ff.rd_data;
    assign link.ck = r_ff.ck;
    assign link.reset_n = r_ff.rst_n;
    assign link.cke = r_ff.cke;
    assign link.cs_n = r_ff.cs_n;
    assign link.ras_n = r_ff.cmd[2];
    assign link.cas_n = r_ff.cmd[1];
    assign link.we_n = r_ff.cmd[0];
    assign link.ba = r_ff.ba;
    assign link.addr = r_ff.addr;
    assign link.odt = r_ff.odt;
endmodule
`default_nettype wire

// ===== bench/dmdc_chk.sv
// link checker: command and strobe relations seen on the wire, link clock domain
// assumes the dmdc_if signals are wired in by name beside the interface
`timescale 1ns/1ps
`default_nettype none
`include "dmdc_consts.svh"
module dmdc_chk (
    // link
    input wire logic ck,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [12:0] addr,
    input wire logic odt,
    input wire logic [7:0] dq,
    input wire logic dqs
);
    logic mrs;
    logic rd;
    logic dll_ff;
    logic cal_ff;
    logic dyn_ff;
    logic [3:0] since_rd_ff;
    assign mrs = !cs_n && {ras_n, cas_n, we_n} == `DMDC_CMD_MRS;
    assign rd = !cs_n && {ras_n, cas_n, we_n} == `DMDC_CMD_RD;
    default clocking cb @(posedge ck); endclocking
    default disable iff (!reset_n);
    // ****************
    // mode bits and cycles since the last read, tracked from the commands on the wire
    // ****************
    always_ff @(posedge ck) begin
        if (!reset_n) begin
            dll_ff <= 1'b0;
            cal_ff <= 1'b0;
            dyn_ff <= 1'b0;
            since_rd_ff <= 4'hf;
        end else begin
            if (mrs && ba == `DMDC_BA_MR1) dll_ff <= addr[0];
            if (mrs && ba == `DMDC_BA_MR3) cal_ff <= addr[2];
            if (mrs && ba == `DMDC_BA_MR2) dyn_ff <= |addr[10:9];
            since_rd_ff <= rd ? 4'h0 : since_rd_ff + {3'h0, since_rd_ff != 4'hf};
        end
    end
    // ****************
    // properties
    // ****************
    sequence s_srx_hold;
        (cke && !odt) [*8];
    endsequence
    property p_mr3_resv;
        mrs && ba[1:0] == 2'h3 |-> addr[12:3] == 10'h000 && !ba[2];
    endproperty
    a_mr3_resv: assert property (p_mr3_resv) else $error("reserved bits set");
    property p_cal_only;
        cal_ff && !cs_n |-> (rd || (mrs && ba == `DMDC_BA_MR3)) && cke;
    endproperty
    a_cal_only: assert property (p_cal_only) else $error("bad command in pattern");
    property p_rd_lat_off;
        rd && dll_ff |-> ##[4:6] dqs;
    endproperty
    a_rd_lat_off: assert property (p_rd_lat_off) else $error("strobe late");
    property p_no_stray_dqs;
        dqs |-> since_rd_ff <= 4'h8;
    endproperty
    a_no_stray_dqs: assert property (p_no_stray_dqs) else $error("stray strobe");
    property p_tmod_hold;
        mrs && ba == `DMDC_BA_MR1 && addr[0] |=> cke [*8];
    endproperty
    a_tmod_hold: assert property (p_tmod_hold) else $error("cke dropped early");
    property p_srx_hold;
        $rose(cke) |-> s_srx_hold;
    endproperty
    a_srx_hold: assert property (p_srx_hold) else $error("exit hold broken");
    property p_dyn_off;
        mrs && ba == `DMDC_BA_MR1 && addr[0] |-> !dyn_ff;
    endproperty
    a_dyn_off: assert property (p_dyn_off) else $error("dynamic term left on");
    property p_lat6;
        mrs && dll_ff && ba == `DMDC_BA_MR0 |-> addr[6:4] == 3'h2;
    endproperty
    a_lat6: assert property (p_lat6) else $error("latency not six");
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// top of the bench: both ends joined over the link, driven through their sequences
// assumes package, interface and constants header are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "dmdc_consts.svh"
module testbench;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic vld = 1'b0;
    dmdc_pkg::dmdc_op_t op = dmdc_pkg::OP_RAW;
    logic [2:0] cmd = `DMDC_CMD_NOP;
    logic [2:0] ba = 3'h0;
    logic [12:0] addr = 13'h0000;
    logic rdy, busy, c_dll, c_cal, d_dll, d_cal, rvld, t;
    logic [7:0] rdat;
    logic [1:0] rtt_wr;
    int err_count = 0;
    int checked = 0;
    int nrd = 0;
    always #12.5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) if (rvld === 1'b1) nrd <= nrd + 1;
    dmdc_if lnk();
    dmdc_ctl dmdc_ctl_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req_valid(vld), .i_req_op(op),
        .i_req_cmd(cmd), .i_req_ba(ba), .i_req_addr(addr), .i_req_odt(1'b0), .o_req_ready(rdy),
        .o_busy(busy), .o_dll_off(c_dll), .o_cal_on(c_cal), .o_rd_valid(rvld),
        .o_rd_data(rdat), .link(lnk));
    dmdc_dev dmdc_dev_i (.link(lnk), .i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_array_data(8'ha5), .o_array_rd(), .o_array_col(), .o_rtt_nom(), .o_rtt_wr(rtt_wr),
        .o_rtt_wr_apply(), .o_dll_off(d_dll), .o_cal_on(d_cal));
    dmdc_chk dmdc_chk_i (.ck(lnk.ck), .reset_n(lnk.reset_n), .cke(lnk.cke), .cs_n(lnk.cs_n),
        .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n), .ba(lnk.ba), .addr(lnk.addr),
        .odt(lnk.odt), .dq(lnk.dq), .dqs(lnk.dqs));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // bounded wait for ready; a refused request just times out with took low
    task automatic go(input dmdc_pkg::dmdc_op_t o, input logic [2:0] c, input logic [2:0] b,
            input logic [12:0] a, output logic took);
        took = 1'b0;
        op <= o;
        cmd <= c;
        ba <= b;
        addr <= a;
        vld <= 1'b1;
        for (int n = 0; n < 40 && !took; n++) begin
            @(posedge i_sys_clk);
            took = rdy;
        end
        vld <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge i_sys_clk);
        repeat (12) @(posedge i_sys_clk);
    endtask
    task automatic rd(input logic [7:0] exp);
        int n0;
        n0 = nrd;
        go(dmdc_pkg::OP_RAW, `DMDC_CMD_RD, 3'h0, 13'h0005, t);
        repeat (80) @(posedge i_sys_clk);
        chk(8'(nrd - n0), 8'h01, "read count");
        chk(rdat, exp, "read data");
    endtask
    task automatic do_reset();
        i_rst <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic t_term();
        go(dmdc_pkg::OP_RAW, `DMDC_CMD_MRS, `DMDC_BA_MR2, 13'h0600, t);
        chk(rtt_wr, 8'h03, "dyn term");
        go(dmdc_pkg::OP_RAW, `DMDC_CMD_NOP, `DMDC_BA_MR2, 13'h0000, t);
        chk(rtt_wr, 8'h03, "after nop");
        go(dmdc_pkg::OP_RAW, `DMDC_CMD_MRS, `DMDC_BA_MR1, 13'h0080, t);
        chk(rtt_wr, 8'h00, "leveling term");
        go(dmdc_pkg::OP_RAW, `DMDC_CMD_MRS, `DMDC_BA_MR1, 13'h0000, t);
    endtask
    task automatic t_off();
        go(dmdc_pkg::OP_DLL_OFF, `DMDC_CMD_NOP, 3'h0, 13'h0000, t);
        chk(d_dll, 8'h01, "dev dll off");
        chk(c_dll, 8'h01, "ctl dll off");
        rd(8'ha5);
    endtask
    task automatic t_cal();
        go(dmdc_pkg::OP_CAL_ON, `DMDC_CMD_NOP, 3'h0, 13'h0000, t);
        chk(d_cal, 8'h01, "pattern on");
        rd(`DMDC_CAL_PATTERN);
        go(dmdc_pkg::OP_DLL_ON, `DMDC_CMD_NOP, 3'h0, 13'h0000, t);
        chk(t, 8'h00, "refused");
        go(dmdc_pkg::OP_CAL_OFF, `DMDC_CMD_NOP, 3'h0, 13'h0000, t);
        chk(d_cal, 8'h00, "pattern off");
        rd(8'ha5);
    endtask
    task automatic t_on();
        go(dmdc_pkg::OP_DLL_ON, `DMDC_CMD_NOP, 3'h0, 13'h0000, t);
        chk(d_dll, 8'h00, "dll on");
        rd(8'ha5);
        go(dmdc_pkg::OP_CAL_ON, `DMDC_CMD_NOP, 3'h0, 13'h0000, t);
        do_reset();
        chk(c_cal, 8'h00, "reset in pattern");
        rd(8'ha5);
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge i_sys_clk);
        err_count++;
        report_and_stop();
    end
    initial begin
        do_reset();
        t_term();
        t_off();
        t_cal();
        t_on();
        report_and_stop();
    end
endmodule
`default_nettype wire
